// *** cpr_asserts.sv ***
// pin-side assertions for the power-down reset block
// assumes it is bound into cpr_top and sees its pins only
`timescale 1ns/1ps
module cpr_asserts
	import cpr_pkg::*;
#(
	parameter int SYNC_STUCK_LIMIT = SYNC_STUCK_CYC
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// pins and state
	input wire logic power_down_reset_n,
	input wire logic line_codec_power_down,
	input wire cpr_oe_s out_oe,
	input wire logic power_down_active,
	input wire logic line_codec_down
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_PIN_HOLDS: assert property (!power_down_reset_n [*3] |-> power_down_active)
		else $error("pin low but running");
	AST_FAST_ENTRY: assert property ($fell(power_down_reset_n) |-> ##[0:2] power_down_active)
		else $error("slow reset entry");
	AST_SYNC_EXIT: assert property ($rose(power_down_reset_n) && power_down_active |=> power_down_active)
		else $error("release not synchronised");
	AST_ALL_HIZ: assert property (power_down_active |-> out_oe == '0)
		else $error("output driven in reset");
	AST_ACOUSTIC_ON: assert property (!power_down_active |-> &out_oe[5:3])
		else $error("acoustic side off");
	AST_LINE_HIZ: assert property (line_codec_down |-> out_oe[2:0] == 3'h0)
		else $error("line output driven");
	AST_LINE_ON: assert property (!power_down_active && !line_codec_down |-> out_oe[2:0] == 3'h7)
		else $error("line output off");
	AST_CLEAN_EXIT: assert property ($fell(power_down_active) && !line_codec_power_down |-> !line_codec_down)
		else $error("line down kept over reset");
endmodule : cpr_asserts

bind cpr_top cpr_asserts #(.SYNC_STUCK_LIMIT(SYNC_STUCK_LIMIT)) chk_u (.clk(clk), .rst_n(rst_n),
	.power_down_reset_n(power_down_reset_n), .line_codec_power_down(line_codec_power_down),
	.out_oe(out_oe), .power_down_active(power_down_active), .line_codec_down(line_codec_down));

// *** cpr_host.sv ***
// host model driving the reset, strap and frame sync pins
// assumes the bench asks for strap changes and stuck sync
`timescale 1ns/1ps
module cpr_host
(
	// clock and bench requests
	input wire logic clk,
	input wire logic hold_rst,
	input wire logic line_want,
	input wire logic ext_want,
	input wire logic sync_stuck,
	// device pins
	output logic power_down_reset_n,
	output logic line_codec_power_down,
	output logic frame_clock_source_select,
	output logic frame_sync
);
	logic [2:0] div;
	logic [3:0] pulse;
	initial
	begin
		{power_down_reset_n, line_codec_power_down, frame_clock_source_select, frame_sync} = 4'h8;
		div = 3'h0;
		pulse = 4'h0;
	end
	always @(posedge clk)
	begin
		div <= div + 3'h1;
		if (!sync_stuck && div == 3'h0)
			frame_sync <= !frame_sync;
		if ({line_want, ext_want} != {line_codec_power_down, frame_clock_source_select})
		begin
			{line_codec_power_down, frame_clock_source_select} <= {line_want, ext_want};
			pulse <= 4'h8;
		end
		else if (pulse != 4'h0)
			pulse <= pulse - 4'h1;
		power_down_reset_n <= !hold_rst && pulse == 4'h0;
	end
endmodule : cpr_host

// *** cpr_pkg.sv ***
// constants, types and register map of the codec power-down and reset control block
// assumes a single 25 MHz clock and an AXI4-Lite register port with 32-bit data
package cpr_pkg;

	// clock and timing
	localparam int CLK_HZ = 25_000_000;
	localparam int SYNC_STUCK_US = 250;
	localparam int SYNC_STUCK_CYC = (CLK_HZ / 1_000_000) * SYNC_STUCK_US;
	localparam int STUCK_CNT_W = 16;

	// register map, byte addresses
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] PRIMARY_ADDR = 4'h0;
	localparam logic [ADDR_W-1:0] AUX_ADDR = 4'h4;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h8;

	// primary_control_reg fields
	localparam int PRI_PDR_BIT = 7;
	localparam int PRI_RUN_BIT = 6;
	localparam int PRI_LINE_PD_BIT = 5;
	localparam logic [7:0] PRIMARY_RST = 8'h00;
	localparam logic [7:0] PRIMARY_WMASK = 8'he0;

	// aux_control_reg fields
	localparam int AUX_SYNC_LOSS_BIT = 0;
	localparam logic [7:0] AUX_RST = 8'h00;
	localparam logic [7:0] AUX_WMASK = 8'h01;

	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// operating mode
	typedef enum logic [2:0] {
		MODE_PDR = 3'b001,
		MODE_INIT = 3'b010,
		MODE_RUN = 3'b100
	} cpr_mode_e;

	// output enables of the analog outputs, high while driven
	typedef struct packed {
		logic acoustic_gain_out;
		logic acoustic_voice_out;
		logic acoustic_drive_out;
		logic line_gain_out;
		logic line_voice_out;
		logic line_drive_out;
	} cpr_oe_s;

	// status register layout, bit 0 is the last member
	typedef struct packed {
		logic sync_stuck_seen;
		logic pin_level;
		logic run;
		logic initial_mode;
		logic line_down;
		logic pdr_active;
	} cpr_status_s;

endpackage : cpr_pkg

// *** cpr_sync.sv ***
// two-flop synchroniser, one pair of flops per bit
// assumes arst_n is an active-low asynchronous clear and d comes from outside the clock domain
`timescale 1ns/1ps
module cpr_sync
#(
	parameter int W = 1
)
(
	// clock and clear
	input wire logic clk,
	input wire logic arst_n,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] stage1;

	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			always_ff @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					stage1[i] <= 1'b0;
					q[i] <= 1'b0;
				end
				else
				begin
					stage1[i] <= d[i];
					q[i] <= stage1[i];
				end
			end
		end
	endgenerate

endmodule : cpr_sync

// *** cpr_top.sv ***
// power-down reset and line codec power-down control with an AXI4-Lite register port
// assumes the pins arrive asynchronously; the analog drivers take the output enables
//
// Summary of operation
// RULE1 - power_down_reset_n low holds device powered down
// RULE2 - power-down reset clears control bits and state
// RULE3 - release enters initial mode, not old configuration
// RULE4 - pin low or primary bit 7 means reset
// RULE5 - host keeps power_down_reset_n high normally
// RULE6 - line_codec_power_down high stops only line codec
// RULE7 - line power-down is pin OR primary bit 5
// RULE8 - powered-down line codec outputs go high-impedance
// RULE9 - host resets after changing line_codec_power_down
// RULE10 - all analog outputs high-impedance during reset
// RULE11 - stuck external frame_sync forces power-down reset
// RULE12 - reset asserts asynchronously, releases through two flops
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module cpr_top
	import cpr_pkg::*;
#(
	parameter int SYNC_STUCK_LIMIT = SYNC_STUCK_CYC
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// device pins
	input wire logic power_down_reset_n,
	input wire logic line_codec_power_down,
	input wire logic frame_clock_source_select,
	input wire logic frame_sync,
	// analog output enables
	output cpr_oe_s out_oe,
	// state
	output logic power_down_active,
	output logic line_codec_down,
	// axi4-lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	// axi4-lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// axi4-lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// axi4-lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	// axi4-lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp
);

	logic pin_rst_n_sync;
	logic [2:0] pins_sync;
	logic line_pin_sync;
	logic ext_clock_sync;
	logic frame_sync_q;
	logic frame_sync_prev;
	logic line_pin_latched;
	logic ext_clock_latched;
	logic [7:0] primary;
	logic [7:0] aux;
	logic [7:0] next_primary;
	logic [7:0] next_aux;
	logic pdr_active;
	logic line_down;
	logic [STUCK_CNT_W-1:0] stuck_cnt;
	logic sync_stuck;
	logic sync_stuck_seen;
	logic stuck_watch;
	logic frame_edge;
	cpr_mode_e mode;
	cpr_mode_e next_mode;
	cpr_oe_s next_oe;
	cpr_status_s status;
	logic aw_held;
	logic [ADDR_W-1:0] aw_addr;
	logic w_held;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic wr_primary;
	logic wr_aux;
	logic wr_mapped;
	logic rd_take;
	logic rd_mapped;
	logic [31:0] rd_value;

	localparam logic [STUCK_CNT_W-1:0] STUCK_LAST = STUCK_CNT_W'(SYNC_STUCK_LIMIT - 1);

	// RULE12 async assert, two-flop release
	cpr_sync #(
		.W(1)
	) u_rst_sync (
		.clk(clk),
		.arst_n(rst_n & power_down_reset_n),
		.d(1'b1),
		.q(pin_rst_n_sync)
	);

	cpr_sync #(
		.W(3)
	) u_pin_sync (
		.clk(clk),
		.arst_n(rst_n),
		.d({line_codec_power_down, frame_clock_source_select, frame_sync}),
		.q(pins_sync)
	);

	assign line_pin_sync = pins_sync[2];
	assign ext_clock_sync = pins_sync[1];
	assign frame_sync_q = pins_sync[0];

	// RULE4 pin low or bit set
	// RULE1 pin low holds power-down
	assign pdr_active = !pin_rst_n_sync || primary[PRI_PDR_BIT];

	// RULE7 pin or register bit
	// RULE6 only the line codec
	assign line_down = line_pin_latched || primary[PRI_LINE_PD_BIT];

	// pin straps follow the pins during reset and freeze on its release
	// RULE9 pin change needs reset
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			line_pin_latched <= 1'b0;
			ext_clock_latched <= 1'b0;
		end
		else if (pdr_active)
		begin
			line_pin_latched <= line_pin_sync;
			ext_clock_latched <= ext_clock_sync;
		end
	end

	// frame_sync watchdog, only in external clock mode with the enable on
	assign frame_edge = frame_sync_q != frame_sync_prev;
	assign stuck_watch = ext_clock_latched && aux[AUX_SYNC_LOSS_BIT] && !pdr_active;
	// RULE11 stuck frame sync
	assign sync_stuck = stuck_watch && !frame_edge && (stuck_cnt == STUCK_LAST);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			frame_sync_prev <= 1'b0;
			stuck_cnt <= '0;
		end
		else
		begin
			frame_sync_prev <= frame_sync_q;
			if (!stuck_watch || frame_edge || sync_stuck)
				stuck_cnt <= '0;
			else
				stuck_cnt <= stuck_cnt + STUCK_CNT_W'(1);
		end
	end

	// sticky record of a watchdog trip, kept across power-down reset
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			sync_stuck_seen <= 1'b0;
		else if (sync_stuck)
			sync_stuck_seen <= 1'b1;
		else if (wr_aux && w_data[AUX_SYNC_LOSS_BIT])
			sync_stuck_seen <= 1'b0;
	end

	// register write decode
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign wr_primary = do_write && (aw_addr == PRIMARY_ADDR) && w_strb[0];
	assign wr_aux = do_write && (aw_addr == AUX_ADDR) && w_strb[0];
	assign wr_mapped = (aw_addr == PRIMARY_ADDR) || (aw_addr == AUX_ADDR) || (aw_addr == STATUS_ADDR);

	// RULE2 clear primary bits 6:0 and aux while in reset, bit 7 kept
	// RULE11 trip sets bit 7, wins over a clear
	assign next_primary[PRI_PDR_BIT] = sync_stuck ||
		(wr_primary ? w_data[PRI_PDR_BIT] : primary[PRI_PDR_BIT]);
	assign next_primary[PRI_PDR_BIT-1:0] = pdr_active ? PRIMARY_RST[PRI_PDR_BIT-1:0] :
		wr_primary ? (w_data[PRI_PDR_BIT-1:0] & PRIMARY_WMASK[PRI_PDR_BIT-1:0]) :
		primary[PRI_PDR_BIT-1:0];
	assign next_aux = pdr_active ? AUX_RST :
		wr_aux ? (w_data[7:0] & AUX_WMASK) : aux;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			primary <= PRIMARY_RST;
			aux <= AUX_RST;
		end
		else
		begin
			primary <= next_primary;
			aux <= next_aux;
		end
	end

	// operating mode
	always_comb
	begin
		next_mode = mode;
		case (mode)
			MODE_PDR:
			begin
				// RULE3 release to initial mode
				if (!pdr_active)
					next_mode = MODE_INIT;
			end
			MODE_INIT:
			begin
				if (pdr_active)
					next_mode = MODE_PDR;
				else if (primary[PRI_RUN_BIT])
					next_mode = MODE_RUN;
			end
			MODE_RUN:
			begin
				if (pdr_active)
					next_mode = MODE_PDR;
			end
			default:
			begin
				next_mode = MODE_PDR;
			end
		endcase
	end

	// RULE2 state returns to reset value
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			mode <= MODE_PDR;
		else if (pdr_active)
			mode <= MODE_PDR;
		else
			mode <= next_mode;
	end

	// RULE10 all outputs off in reset
	assign next_oe.acoustic_gain_out = !pdr_active;
	assign next_oe.acoustic_voice_out = !pdr_active;
	assign next_oe.acoustic_drive_out = !pdr_active;
	// RULE8 line outputs off when down
	assign next_oe.line_gain_out = !pdr_active && !line_down;
	assign next_oe.line_voice_out = !pdr_active && !line_down;
	assign next_oe.line_drive_out = !pdr_active && !line_down;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			out_oe <= '0;
			power_down_active <= 1'b1;
			line_codec_down <= 1'b0;
		end
		else
		begin
			out_oe <= next_oe;
			power_down_active <= pdr_active;
			line_codec_down <= line_down;
		end
	end

	// write channels, taken in either order
	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_held <= 1'b0;
			aw_addr <= '0;
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end
		else
		begin
			if (s_axi_awvalid && !aw_held)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			else if (do_write)
				aw_held <= 1'b0;
			if (s_axi_wvalid && !w_held)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			else if (do_write)
				w_held <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// read path
	assign status.sync_stuck_seen = sync_stuck_seen;
	assign status.pin_level = pin_rst_n_sync;
	assign status.run = mode == MODE_RUN;
	assign status.initial_mode = mode == MODE_INIT;
	assign status.line_down = line_down;
	assign status.pdr_active = pdr_active;

	assign s_axi_arready = !s_axi_rvalid;
	assign rd_take = s_axi_arvalid && !s_axi_rvalid;
	assign rd_mapped = (s_axi_araddr == PRIMARY_ADDR) || (s_axi_araddr == AUX_ADDR) ||
		(s_axi_araddr == STATUS_ADDR);
	assign rd_value = (s_axi_araddr == PRIMARY_ADDR) ? {24'h000000, primary} :
		(s_axi_araddr == AUX_ADDR) ? {24'h000000, aux} :
		(s_axi_araddr == STATUS_ADDR) ? {26'h0000000, status} :
		32'h00000000;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (rd_take)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_value;
			s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

endmodule : cpr_top

// *** cpr_top_tb.sv ***
// self-checking bench for the power-down reset block
// assumes cpr_host on the pins and an axi4-lite master here
`timescale 1ns/1ps
module cpr_top_tb;
	import cpr_pkg::*;
	localparam int LIM = 20;
	logic clk, rst_n, hold_rst, line_want, ext_want, sync_stuck;
	logic pdr_n, lpd, csel, fs, pda, lcd;
	cpr_oe_s oe;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [3:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	int num_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	cpr_host host_u (.clk(clk), .hold_rst(hold_rst), .line_want(line_want), .ext_want(ext_want),
		.sync_stuck(sync_stuck), .power_down_reset_n(pdr_n), .line_codec_power_down(lpd),
		.frame_clock_source_select(csel), .frame_sync(fs));
	cpr_top #(.SYNC_STUCK_LIMIT(LIM)) dut_u (.clk(clk), .rst_n(rst_n), .power_down_reset_n(pdr_n),
		.line_codec_power_down(lpd), .frame_clock_source_select(csel), .frame_sync(fs), .out_oe(oe),
		.power_down_active(pda), .line_codec_down(lcd), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task summarize;
		$display("tests %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			num_errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	// pda, lcd and the six enables
	task pin(input logic [7:0] e);
		@(negedge clk);
		chk({pda, lcd, oe}, e);
		// hand back on a rising edge so that the next stimulus starts there
		@(posedge clk);
	endtask : pin
	// one axi4-lite write (w=1) or read, waiting for the answer
	task acc(input logic w, input logic [3:0] a, input logic [31:0] d,
		input logic [31:0] m = 32'hffffffff, input logic [1:0] e = RESP_OKAY);
		logic ta, tw, done;
		logic [31:0] rv;
		logic [1:0] rs;
		awaddr <= a;
		araddr <= a;
		wdata <= d;
		awvalid <= w;
		wvalid <= w;
		bready <= w;
		arvalid <= !w;
		rready <= !w;
		done = 1'b0;
		// no timeout of its own; the wait ends on the answer or at the bench timeout
		while (!done)
		begin
			@(negedge clk);
			ta = awvalid && awready || arvalid && arready;
			tw = wvalid && wready;
			done = w ? bvalid : rvalid;
			rv = rdata;
			rs = w ? bresp : rresp;
			@(posedge clk);
			if (ta)
			begin
				awvalid <= 1'b0;
				arvalid <= 1'b0;
			end
			if (tw)
				wvalid <= 1'b0;
			if (done)
			begin
				bready <= 1'b0;
				rready <= 1'b0;
			end
		end
		@(posedge clk);
		chk(rs, e);
		if (!w)
			chk(rv & m, d);
	endtask : acc
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 2000)
		begin
			num_errors++;
			summarize();
		end
	end
	initial
	begin
		{rst_n, hold_rst, line_want, ext_want, sync_stuck} = '0;
		{awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
		tick(5);
		pin(8'h80);
		tick(4);
		rst_n <= 1'b1;
		tick(8);
		pin(8'h3f);
		acc(0, STATUS_ADDR, 32'h4, 32'h7);
		acc(1, PRIMARY_ADDR, 32'ha0);
		pin(8'h80);
		acc(0, PRIMARY_ADDR, 32'h80);
		acc(1, PRIMARY_ADDR, 32'h40);
		tick(4);
		acc(0, PRIMARY_ADDR, 32'h0);
		pin(8'h3f);
		acc(1, PRIMARY_ADDR, 32'h60);
		tick(3);
		pin(8'h78);
		acc(0, STATUS_ADDR, 32'ha, 32'hf);
		acc(1, AUX_ADDR, 32'h1);
		hold_rst <= 1'b1;
		tick(6);
		pin(8'h80);
		acc(0, STATUS_ADDR, 32'h1, 32'h13);
		hold_rst <= 1'b0;
		tick(8);
		pin(8'h3f);
		acc(0, PRIMARY_ADDR, 32'h0);
		acc(0, AUX_ADDR, 32'h0);
		acc(0, STATUS_ADDR, 32'h4, 32'h7);
		line_want <= 1'b1;
		tick(16);
		pin(8'h78);
		line_want <= 1'b0;
		tick(16);
		pin(8'h3f);
		ext_want <= 1'b1;
		tick(16);
		acc(1, AUX_ADDR, 32'h1);
		tick(40);
		pin(8'h3f);
		sync_stuck <= 1'b1;
		tick(LIM + 16);
		pin(8'h80);
		acc(0, PRIMARY_ADDR, 32'h80);
		acc(0, AUX_ADDR, 32'h0);
		acc(0, STATUS_ADDR, 32'h31, 32'h3f);
		sync_stuck <= 1'b0;
		acc(1, PRIMARY_ADDR, 32'h0);
		tick(8);
		pin(8'h3f);
		acc(1, AUX_ADDR, 32'h1);
		acc(0, STATUS_ADDR, 32'h14, 32'h3f);
		acc(1, 4'hc, 32'h1, 32'h0, RESP_SLVERR);
		acc(0, 4'hc, 32'h0, 32'hffffffff, RESP_SLVERR);
		summarize();
	end
endmodule : cpr_top_tb
